// *** fop_pkg.sv ***
// shared types and constants of the float operator block
package fop_pkg;

  // ---------------------------------------------------------------
  // widths and ring depth
  // ---------------------------------------------------------------
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned LAT_W   = 7;
  localparam int unsigned DEPTH   = 128;
  localparam int unsigned IRQ_W   = 3;

  // ---------------------------------------------------------------
  // register byte offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [4:0]  CFG_OFS      = 5'h00;
  localparam logic [4:0]  TIME_OFS     = 5'h04;
  localparam logic [4:0]  STAT_OFS     = 5'h08;
  localparam logic [4:0]  IRQ_ST_OFS   = 5'h0c;
  localparam logic [4:0]  IRQ_MASK_OFS = 5'h10;
  localparam logic [31:0] CFG_RST      = 32'h1ff30620;
  localparam logic [6:0]  LAT_REQ_RST  = 7'h7f;
  localparam logic [6:0]  RATE_RST     = 7'h01;
  localparam int unsigned RATE_POS     = 8;
  localparam int unsigned MAXLAT_POS   = 8;
  localparam int unsigned SEQ_POS      = 16;

  // interrupt status bits
  localparam int unsigned IRQ_DONE  = 0;
  localparam int unsigned IRQ_SPACE = 1;
  localparam int unsigned IRQ_EXC   = 2;

  // fraction widths that name the standard precisions
  localparam logic [6:0]  FW_SINGLE = 7'h18;
  localparam logic [6:0]  FW_DOUBLE = 7'h35;

  // ---------------------------------------------------------------
  // enumerations
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_ADD = 3'h0, OP_MUL = 3'h1, OP_DIV = 3'h2, OP_SQRT = 3'h3,
    OP_CMP = 3'h4, OP_FIX2FLT = 3'h5, OP_FLT2FIX = 3'h6, OP_FLT2FLT = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    IMPL_LOGIC_SPEED = 2'h0, IMPL_LOGIC_LOWLAT = 2'h1,
    IMPL_SLICE_FULL  = 2'h2, IMPL_SLICE_MAX    = 2'h3
  } impl_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00, BUS_ACK = 2'b01
  } bus_state_e;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] rsvd;
    logic       has_sync_clear_in;
    logic       has_ce;
    logic       has_dz;
    logic       has_inv;
    logic       has_of;
    logic       has_uf;
    logic       has_rdy;
    logic       has_ready;
    logic       has_valid;
    logic [6:0] rw;
    logic [6:0] fw;
    logic       newfam;
    impl_e      impl;
    op_e        op;
  } cfg_s;

  typedef struct packed {
    logic              valid;
    logic              rdy;
    logic              uf;
    logic              of;
    logic              inv;
    logic              dz;
    logic [DATA_W-1:0] data;
  } entry_s;

  localparam int unsigned ENTRY_W = $bits(entry_s);

endpackage

// *** fop_delay_mem.sv ***
// ring memory that delays result entries, registered read
`timescale 1ns/1ps
module fop_delay_mem
  import fop_pkg::*;
(
  input  wire logic       mclk_i,   // clock
  input  wire logic       rst_i,    // sync reset
  input  wire logic       clr_i,    // drops every stored entry
  input  wire logic       en_i,     // advance enable
  input  wire logic [6:0] waddr_i,  // write slot
  input  wire entry_s     wdata_i,  // entry written each enabled cycle
  input  wire logic [6:0] raddr_i,  // read slot
  output entry_s          rdata_o   // registered read entry
);

  logic [ENTRY_W-2:0] store_ff [DEPTH];
  logic [DEPTH-1:0]   vld_ff;

  // payload array, no reset needed: guarded by the valid bits
  always_ff @(posedge mclk_i) begin
    if (en_i) begin
      store_ff[waddr_i] <= wdata_i[ENTRY_W-2:0];
    end
  end

  // valid bits, cleared together so a flush costs one cycle
  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_i) begin
      vld_ff <= '0;
    end else if (en_i) begin
      vld_ff[waddr_i] <= wdata_i.valid;
    end
  end

  // invalid slots read as all zero so no stale flag leaks out;
  // latency one reads the slot being written, so that entry is passed straight on
  always_ff @(posedge mclk_i) begin
    if (rst_i || clr_i) begin
      rdata_o <= '0;
    end else if (en_i && raddr_i == waddr_i) begin
      rdata_o <= wdata_i.valid ? wdata_i : '0;
    end else if (en_i) begin
      rdata_o <= vld_ff[raddr_i] ? {1'b1, store_ff[raddr_i]} : '0;
    end
  end

endmodule

// *** float_operator_latency_rate.sv ***
// float operator shell: latency, rate, optional pins, avalon control
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
// Operation
// - double multiply on slices, low latency, max usage: latency up to 10; the code allows 10 on the newer family only, 9 on the older
// - slice adder limit: 16 single, 15 double; newer slice 11 and 14
// - older logic adder limit from 9 to 15 by fraction width
// - newer low-latency logic adder limit 8 for single and double
// - newer speed logic adder limit from 8 to 13 by fraction width
// - fixed to float limit 5, 6 or 7 by operand width
// - float to fixed limit 5, 6 or 7 by larger of fraction+1, result
// - sequential when rate is fraction+1 for root, fraction+2 for divide
// - zero divisor flag only exists for divide
// - valid, ready, result valid, enable, clear each optional
// - underflow, overflow, invalid flags each optional
// - latency is the configured count, 1 up to the limit; a count of 0 is served as 1
module float_operator_latency_rate
  import fop_pkg::*;
(
  input  wire logic        mclk_i,              // 250 MHz clock
  input  wire logic        rst_i,               // sync reset, active high
  input  wire logic        ce_i,                // datapath clock enable
  input  wire logic        sync_clear_in_i,     // datapath sync clear
  input  wire logic [4:0]  avs_address_i,       // byte address
  input  wire logic        avs_read_i,          // read request
  input  wire logic        avs_write_i,         // write request
  input  wire logic [31:0] avs_writedata_i,     // write data
  input  wire logic [3:0]  avs_byteenable_i,    // byte lanes
  output logic      [31:0] avs_readdata_o,      // read data
  output logic             avs_waitrequest_o,   // stall
  output logic             irq_o,               // level interrupt
  input  wire logic [31:0] operand_a_i,         // operand a
  input  wire logic [31:0] operand_b_i,         // operand b
  input  wire logic        operand_valid_in_i,  // operands present
  output logic             operation_ready_o,   // may take operands
  output logic      [31:0] result_o,            // result word
  output logic             result_valid_o,      // result pulse
  output logic             underflow_o,         // underflow flag
  output logic             overflow_o,          // overflow flag
  output logic             invalid_op_o,        // invalid operation
  output logic             zero_divisor_flag_o  // zero_divisor_flag
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    be_merge = (old_v & ~m) | (new_v & m);
  endfunction

  // highest latency the configured operator allows
  function automatic logic [6:0] lat_max(input cfg_s c);
    logic       sgl;
    logic       dbl;
    logic [6:0] fw;
    logic [6:0] m;
    sgl = (c.fw == FW_SINGLE);
    dbl = (c.fw == FW_DOUBLE);
    fw  = c.fw;
    m   = ((fw + 7'd1) > c.rw) ? fw + 7'd1 : c.rw;
    lat_max = 7'd2;
    case (c.op)
      OP_ADD: begin
        if (c.impl == IMPL_SLICE_FULL && (sgl || dbl)) begin
          if (c.newfam) lat_max = sgl ? 7'd11 : 7'd14;
          else          lat_max = sgl ? 7'd16 : 7'd15;
        end else if (c.impl == IMPL_LOGIC_LOWLAT && c.newfam && (sgl || dbl)) begin
          lat_max = 7'd8;
        end else if (c.newfam) begin
          if      (fw <= 7'd13) lat_max = 7'd8;
          else if (fw == 7'd14) lat_max = 7'd9;
          else if (fw == 7'd15) lat_max = 7'd10;
          else if (fw <= 7'd17) lat_max = 7'd11;
          else if (fw <= 7'd61) lat_max = 7'd12;
          else                  lat_max = 7'd13;
        end else begin
          if      (fw <= 7'd5)  lat_max = 7'd9;
          else if (fw <= 7'd14) lat_max = 7'd10;
          else if (fw == 7'd15) lat_max = 7'd11;
          else if (fw <= 7'd17) lat_max = 7'd12;
          else if (fw <= 7'd29) lat_max = 7'd13;
          else if (fw <= 7'd62) lat_max = 7'd14;
          else                  lat_max = 7'd15;
        end
      end
      OP_MUL: begin
        if (c.impl == IMPL_SLICE_MAX && c.newfam && dbl) lat_max = 7'd10;
        else if (fw <= 7'd5)  lat_max = 7'd5;
        else if (fw <= 7'd11) lat_max = 7'd6;
        else if (fw <= 7'd23) lat_max = 7'd7;
        else if (fw <= 7'd47) lat_max = 7'd8;
        else                  lat_max = 7'd9;
      end
      OP_DIV, OP_SQRT: lat_max = fw + 7'd4;
      OP_CMP:          lat_max = 7'd2;
      OP_FIX2FLT: begin
        if      (fw <= 7'd8)  lat_max = 7'd5;
        else if (fw <= 7'd32) lat_max = 7'd6;
        else                  lat_max = 7'd7;
      end
      OP_FLT2FIX: begin
        if      (m <= 7'd16) lat_max = 7'd5;
        else if (m <= 7'd64) lat_max = 7'd6;
        else                 lat_max = 7'd7;
      end
      default: lat_max = (c.rw < c.fw) ? 7'd3 : 7'd2;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // registers and control state
  // ---------------------------------------------------------------
  cfg_s             cfg_ff;
  logic [6:0]       lat_req_ff;
  logic [6:0]       rate_ff;
  logic [IRQ_W-1:0] irq_st_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] nxt_irq_st;
  logic [IRQ_W-1:0] irq_ev;
  bus_state_e       bus_ff;
  logic [6:0]       eff_lat_ff;
  logic [6:0]       nxt_eff_lat;
  logic [6:0]       max_lat;
  logic [6:0]       rate_eff;
  logic [6:0]       wptr_ff;
  logic [6:0]       gap_ff;
  logic [6:0]       nxt_gap;
  logic             done_d_ff;
  logic             seq_mode;
  logic             ce_eff;
  logic             sync_clear_in_eff;
  logic             valid_eff;
  logic             acc;
  logic             spacing_err;
  logic             wr_take;
  logic [31:0]      rd_word;
  entry_s           wr_ent;
  entry_s           rd_ent;

  assign max_lat  = lat_max(cfg_ff);
  assign rate_eff = (rate_ff == 7'd0) ? 7'd1 : rate_ff;
  // absent control pins fall back to always enabled / never cleared
  assign ce_eff    = !cfg_ff.has_ce || ce_i;
  assign sync_clear_in_eff  = cfg_ff.has_sync_clear_in && sync_clear_in_i;
  assign valid_eff = !cfg_ff.has_valid || operand_valid_in_i;
  // operands are only taken once the spacing count has run out
  assign acc         = ce_eff && !sync_clear_in_eff && valid_eff && (gap_ff == 7'd0);
  assign spacing_err = ce_eff && cfg_ff.has_valid && operand_valid_in_i && (gap_ff != 7'd0);
  // sequential mode is reported, the stand-in datapath is not reshaped
  assign seq_mode = (cfg_ff.op == OP_SQRT && rate_ff == cfg_ff.fw + 7'd1) ||
                    (cfg_ff.op == OP_DIV  && rate_ff == cfg_ff.fw + 7'd2);
  assign wr_take  = (bus_ff == BUS_ACK) && avs_write_i;

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle, then the answer
  // ---------------------------------------------------------------
  always_comb begin
    if (avs_address_i == CFG_OFS) begin
      rd_word = cfg_ff;
    end else if (avs_address_i == TIME_OFS) begin
      rd_word = {17'h0, rate_ff, 1'b0, lat_req_ff};
    end else if (avs_address_i == STAT_OFS) begin
      rd_word = {15'h0, seq_mode, 1'b0, max_lat, 1'b0, eff_lat_ff};
    end else if (avs_address_i == IRQ_ST_OFS) begin
      rd_word = {29'h0, irq_st_ff};
    end else if (avs_address_i == IRQ_MASK_OFS) begin
      rd_word = {29'h0, irq_mask_ff};
    end else begin
      rd_word = 32'h0;
    end
  end

  // handshake state and read data capture
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      bus_ff            <= BUS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o    <= 32'h0;
    end else begin
      case (bus_ff)
        BUS_IDLE: begin
          if (avs_read_i || avs_write_i) begin
            bus_ff            <= BUS_ACK;
            avs_waitrequest_o <= 1'b0;
            if (avs_read_i) avs_readdata_o <= rd_word;
          end
        end
        default: begin
          bus_ff            <= BUS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // software writable registers, written at the completing edge
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cfg_ff      <= cfg_s'(CFG_RST);
      lat_req_ff  <= LAT_REQ_RST;
      rate_ff     <= RATE_RST;
      irq_mask_ff <= '0;
    end else if (wr_take) begin
      if (avs_address_i == CFG_OFS) begin
        cfg_ff <= cfg_s'(be_merge(cfg_ff, avs_writedata_i, avs_byteenable_i));
      end else if (avs_address_i == TIME_OFS) begin
        lat_req_ff <= 7'(be_merge({25'h0, lat_req_ff}, avs_writedata_i, avs_byteenable_i));
        rate_ff    <= 7'(be_merge({17'h0, rate_ff, 8'h0}, avs_writedata_i,
                                  avs_byteenable_i) >> RATE_POS);
      end else if (avs_address_i == IRQ_MASK_OFS) begin
        irq_mask_ff <= IRQ_W'(be_merge({29'h0, irq_mask_ff}, avs_writedata_i,
                                       avs_byteenable_i));
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupts: sticky, write one to clear, a new event wins
  // ---------------------------------------------------------------
  always_comb begin
    irq_ev            = '0;
    irq_ev[IRQ_DONE]  = done_d_ff && rd_ent.valid;
    irq_ev[IRQ_SPACE] = spacing_err;
    irq_ev[IRQ_EXC]   = done_d_ff && (rd_ent.uf || rd_ent.of || rd_ent.inv || rd_ent.dz);
    nxt_irq_st        = irq_st_ff | irq_ev;
    if (wr_take && avs_address_i == IRQ_ST_OFS && avs_byteenable_i[0]) begin
      nxt_irq_st = (irq_st_ff & ~avs_writedata_i[IRQ_W-1:0]) | irq_ev;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      irq_st_ff <= '0;
      irq_o     <= 1'b0;
    end else begin
      irq_st_ff <= nxt_irq_st;
      irq_o     <= |(nxt_irq_st & irq_mask_ff);
    end
  end

  // ---------------------------------------------------------------
  // latency and operand spacing
  // ---------------------------------------------------------------
  // zero is served as one: every result leaves through a register
  always_comb begin
    nxt_eff_lat = (lat_req_ff > max_lat) ? max_lat : lat_req_ff;
    if (nxt_eff_lat == 7'd0) nxt_eff_lat = 7'd1;
  end

  always_comb begin
    nxt_gap = gap_ff;
    if (sync_clear_in_eff) nxt_gap = 7'd0;
    else if (acc) nxt_gap = rate_eff - 7'd1;
    else if (ce_eff && gap_ff != 7'd0) nxt_gap = gap_ff - 7'd1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      eff_lat_ff        <= 7'd1;
      gap_ff            <= 7'd0;
      operation_ready_o <= 1'b1;
      done_d_ff         <= 1'b0;
    end else begin
      eff_lat_ff        <= nxt_eff_lat;
      gap_ff            <= nxt_gap;
      operation_ready_o <= (nxt_gap == 7'd0) || !cfg_ff.has_ready;
      done_d_ff         <= ce_eff && !sync_clear_in_eff;
    end
  end

  // slot pointer of the delay ring, a changed latency garbles flight
  always_ff @(posedge mclk_i) begin
    if (rst_i || sync_clear_in_eff) begin
      wptr_ff <= 7'd0;
    end else if (ce_eff) begin
      wptr_ff <= wptr_ff + 7'd1;
    end
  end

  // ---------------------------------------------------------------
  // stand-in arithmetic: integer ops, ieee core not modelled here
  // ---------------------------------------------------------------
  always_comb begin
    logic [32:0] sum;
    sum          = {1'b0, operand_a_i} + {1'b0, operand_b_i};
    wr_ent       = '0;
    wr_ent.valid = acc;
    wr_ent.rdy   = acc && cfg_ff.has_rdy;
    case (cfg_ff.op)
      OP_ADD:  wr_ent.data = sum[31:0];
      OP_MUL:  wr_ent.data = 32'(operand_a_i * operand_b_i);
      OP_CMP:  wr_ent.data = {31'h0, operand_a_i < operand_b_i};
      default: wr_ent.data = operand_a_i;
    endcase
    wr_ent.of  = cfg_ff.has_of && cfg_ff.op == OP_ADD && sum[32];
    wr_ent.uf  = cfg_ff.has_uf && cfg_ff.op == OP_FLT2FIX &&
                 operand_a_i[30:23] == 8'h00 && operand_a_i[22:0] != 23'h0;
    wr_ent.inv = cfg_ff.has_inv && cfg_ff.op == OP_SQRT && operand_a_i[31];
    wr_ent.dz  = cfg_ff.has_dz && cfg_ff.op == OP_DIV &&
                 operand_b_i == 32'h0;
  end

  // ring written every enabled cycle; read one slot ahead, the read register is the last stage
  fop_delay_mem u_delay (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .clr_i   (sync_clear_in_eff),
    .en_i    (ce_eff),
    .waddr_i (wptr_ff),
    .wdata_i (wr_ent),
    .raddr_i (wptr_ff - eff_lat_ff + 7'd1),
    .rdata_o (rd_ent)
  );

  assign result_o            = rd_ent.data;
  assign result_valid_o      = rd_ent.rdy;
  assign underflow_o         = rd_ent.uf;
  assign overflow_o          = rd_ent.of;
  assign invalid_op_o        = rd_ent.inv;
  assign zero_divisor_flag_o = rd_ent.dz;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_req_idle;
    (avs_read_i || avs_write_i) && bus_ff == BUS_IDLE;
  endsequence
  bus_answer_a: assert property (s_req_idle |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  mul_lowlat_a: assert property (cfg_ff.op == OP_MUL && cfg_ff.impl == IMPL_SLICE_MAX &&
    cfg_ff.newfam && cfg_ff.fw == FW_DOUBLE |-> max_lat == 7'd10)
    else $error("double multiply limit wrong");
  add_slice_a: assert property (cfg_ff.op == OP_ADD && cfg_ff.impl == IMPL_SLICE_FULL &&
    !cfg_ff.newfam && cfg_ff.fw == FW_SINGLE |-> max_lat == 7'd16)
    else $error("slice adder limit wrong");
  add_old_a: assert property (cfg_ff.op == OP_ADD && cfg_ff.impl == IMPL_LOGIC_SPEED &&
    !cfg_ff.newfam && cfg_ff.fw == 7'd63 |-> max_lat == 7'd15)
    else $error("older logic adder limit wrong");
  add_lowlat_a: assert property (cfg_ff.op == OP_ADD && cfg_ff.impl == IMPL_LOGIC_LOWLAT &&
    cfg_ff.newfam && cfg_ff.fw == FW_DOUBLE |-> max_lat == 7'd8)
    else $error("low latency adder limit wrong");
  add_speed_a: assert property (cfg_ff.op == OP_ADD && cfg_ff.impl == IMPL_LOGIC_SPEED &&
    cfg_ff.newfam && cfg_ff.fw == 7'd14 |-> max_lat == 7'd9)
    else $error("speed adder limit wrong");
  fix_float_a: assert property (cfg_ff.op == OP_FIX2FLT && cfg_ff.fw == 7'd9
    |-> max_lat == 7'd6)
    else $error("fixed to float limit wrong");
  float_fix_a: assert property (cfg_ff.op == OP_FLT2FIX && cfg_ff.fw == 7'd64
    |-> max_lat == 7'd7)
    else $error("float to fixed limit wrong");
  sequence s_acc_two;
    acc && rate_ff == 7'd2;
  endsequence
  ready_gap_a: assert property (s_acc_two ##1 (ce_eff && !sync_clear_in_eff)
    |-> gap_ff == 7'd1 && !acc ##1 gap_ff == 7'd0)
    else $error("operand spacing not kept");
  seq_mode_a: assert property (cfg_ff.op == OP_DIV && rate_ff == cfg_ff.fw + 7'd2
    |-> seq_mode)
    else $error("sequential mode not reported");
  zero_div_a: assert property (wr_ent.dz |-> cfg_ff.op == OP_DIV && operand_b_i == 32'h0)
    else $error("zero divisor flag outside divide");
  ready_opt_a: assert property (!cfg_ff.has_ready |=> operation_ready_o)
    else $error("absent ready port not held high");
  sync_clear_in_flush_a: assert property (sync_clear_in_eff |=> !result_valid_o && !rd_ent.valid)
    else $error("clear did not flush results");
  exc_gate_a: assert property (wr_ent.of || wr_ent.uf |-> cfg_ff.has_of || cfg_ff.has_uf)
    else $error("exception flag without its port");
  lat_window_a: assert property ($stable(cfg_ff) && $stable(lat_req_ff)
    |-> eff_lat_ff != 7'd0 && eff_lat_ff <= max_lat)
    else $error("latency outside allowed window");
  result_pulse_a: assert property (result_valid_o && ce_eff && !sync_clear_in_eff && rate_ff == 7'd2 &&
    $stable(eff_lat_ff) |=> !result_valid_o)
    else $error("result valid longer than one cycle");

endmodule

// *** fop_source.sv ***
// operand source for the float operator, offering sets at a chosen spacing
`timescale 1ns/1ps
module fop_source
  import fop_pkg::*;
(
  input  wire logic        mclk_i,  // clock
  output logic      [31:0] opa_o,   // operand a
  output logic      [31:0] opb_o,   // operand b
  output logic             valid_o  // operands present
);
  int unsigned cnt = 0;   // edge count, same origin as the bench
  int unsigned take_q[$]; // edge at which each set was offered

  // ----
  // offer and release
  // ----
  initial begin
    valid_o = 1'b0;
    opa_o   = '0;
    opb_o   = '0;
  end
  always @(posedge mclk_i) cnt <= cnt + 1;

  // one set, then quiet for the rest of the spacing; gap 1 keeps valid up
  task automatic send(input logic [31:0] a, input logic [31:0] b, input int gap);
    opa_o   <= a;
    opb_o   <= b;
    valid_o <= 1'b1;
    @(posedge mclk_i);
    take_q.push_back(cnt);
    if (gap > 1) begin
      idle();
      repeat (gap - 1) @(posedge mclk_i);
    end
  endtask

  // released lines must not keep the last operands on show
  task automatic idle();
    valid_o <= 1'b0;
    opa_o   <= ~opa_o;
    opb_o   <= ~opb_o;
  endtask
endmodule

// *** float_operator_latency_rate_tb.sv ***
// bench for the float operator: registers, latency limits, operand stream
`timescale 1ns/1ps
module float_operator_latency_rate_tb
  import fop_pkg::*;
;
  logic        mclk, rst, rd, wr, wreq, irq, rvalid, valid, clr, rdy;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata, result, opa, opb, q, exp_q[$], res_q[$];
  int unsigned cnt = 0, res_t[$];
  int          failures = 0, tests_run = 0;

  // ----
  // clock, design and source
  // ----
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  float_operator_latency_rate dut_u (.mclk_i(mclk), .rst_i(rst), .ce_i(1'b1),
    .sync_clear_in_i(clr), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .irq_o(irq), .operand_a_i(opa), .operand_b_i(opb),
    .operand_valid_in_i(valid), .operation_ready_o(rdy), .result_o(result),
    .result_valid_o(rvalid), .underflow_o(), .overflow_o(), .invalid_op_o(),
    .zero_divisor_flag_o());
  fop_source src_u (.mclk_i(mclk), .opa_o(opa), .opb_o(opb), .valid_o(valid));

  // a pulse held too long shows up as an extra logged result
  always @(posedge mclk) begin
    cnt <= cnt + 1;
    if (rvalid === 1'b1) begin
      res_q.push_back(result);
      res_t.push_back(cnt);
    end
  end

  // ----
  // tasks
  // ----
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer; request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    rd    <= !w;
    wr    <= w;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    if (n >= 50) begin
      failures++;
      close_out();
    end
    r = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [31:0] mk(input op_e o, input impl_e i, input logic f,
                                     input logic [6:0] fw, input logic [6:0] rw);
    return {3'h0, 9'h1ff, rw, fw, f, i, o};
  endfunction
  // program a setup, read back sequential flag, limit and clamped latency
  task automatic lim(input logic [31:0] c, input logic [15:0] t, input logic [7:0] e);
    logic [31:0] r;
    bus(1, CFG_OFS, c, r);
    bus(1, TIME_OFS, {16'h0, t}, r);
    bus(0, STAT_OFS, '0, r);
    chk("status", {17'h0, r[16], r[14:8], r[6:0]}, {17'h0, e, e[6:0]});
  endtask
  task automatic offer(input logic [31:0] a, input logic [31:0] b, input int gap);
    exp_q.push_back(a + b);
    src_u.send(a, b, gap);
  endtask
  task automatic drain(input int unsigned lat);
    repeat (lat + 6) @(posedge mclk);
    chk("count", 32'(res_q.size()), 32'(exp_q.size()));
    foreach (exp_q[i]) begin
      chk("result", res_q[i], exp_q[i]);
      chk("latency", res_t[i] - src_u.take_q[i], lat);
    end
    exp_q.delete();
    res_q.delete();
    res_t.delete();
    src_u.take_q.delete();
  endtask

  // ----
  // sequence
  // ----
  initial begin
    #400000;
    failures++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = '0;
    wdata = '0;
    clr = 1'b0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    bus(0, CFG_OFS, '0, q);
    chk("config", q, CFG_RST);
    bus(0, TIME_OFS, '0, q);
    chk("timing", q, {17'h0, RATE_RST, 1'b0, LAT_REQ_RST});
    bus(0, STAT_OFS, '0, q);
    chk("status", {17'h0, q[16], q[14:8], q[6:0]}, 32'h60c);
    bus(0, 5'h14, '0, q);
    chk("unmapped", q, 32'h0);
    $display("test reset done");
    lim(mk(OP_ADD, IMPL_LOGIC_SPEED, 1, 7'h0e, FW_SINGLE), 16'h017f, 8'h09);
    lim(mk(OP_ADD, IMPL_LOGIC_SPEED, 1, 7'h3e, FW_SINGLE), 16'h017f, 8'h0d);
    lim(mk(OP_ADD, IMPL_LOGIC_SPEED, 0, 7'h0f, FW_SINGLE), 16'h017f, 8'h0b);
    lim(mk(OP_ADD, IMPL_LOGIC_SPEED, 0, 7'h3f, FW_SINGLE), 16'h017f, 8'h0f);
    lim(mk(OP_ADD, IMPL_LOGIC_LOWLAT, 1, FW_DOUBLE, FW_DOUBLE), 16'h017f, 8'h08);
    lim(mk(OP_ADD, IMPL_SLICE_FULL, 0, FW_SINGLE, FW_SINGLE), 16'h017f, 8'h10);
    lim(mk(OP_ADD, IMPL_SLICE_FULL, 1, FW_DOUBLE, FW_DOUBLE), 16'h017f, 8'h0e);
    lim(mk(OP_MUL, IMPL_SLICE_MAX, 1, FW_DOUBLE, FW_DOUBLE), 16'h017f, 8'h0a);
    lim(mk(OP_FLT2FIX, IMPL_LOGIC_SPEED, 1, 7'h10, 7'h08), 16'h017f, 8'h06);
    lim(mk(OP_FLT2FIX, IMPL_LOGIC_SPEED, 1, 7'h04, 7'h10), 16'h017f, 8'h05);
    lim(mk(OP_FLT2FIX, IMPL_LOGIC_SPEED, 1, 7'h40, 7'h08), 16'h017f, 8'h07);
    lim(mk(OP_FIX2FLT, IMPL_LOGIC_SPEED, 1, 7'h09, FW_SINGLE), 16'h017f, 8'h06);
    lim(mk(OP_SQRT, IMPL_LOGIC_SPEED, 1, FW_SINGLE, FW_SINGLE), 16'h197f, 8'h9c);
    lim(mk(OP_DIV, IMPL_LOGIC_SPEED, 1, FW_SINGLE, FW_SINGLE), 16'h1a7f, 8'h9c);
    lim(mk(OP_DIV, IMPL_LOGIC_SPEED, 1, FW_SINGLE, FW_SINGLE), 16'h197f, 8'h1c);
    $display("test limits done");
    bus(1, CFG_OFS, CFG_RST, q);
    bus(1, TIME_OFS, 32'h103, q);
    bus(0, STAT_OFS, '0, q);
    chk("eff latency", {25'h0, q[6:0]}, 32'h3);
    for (int i = 0; i < 3; i++) offer(32'h11 * i, 32'h100 << i, 1);
    src_u.idle();
    drain(3);
    bus(1, TIME_OFS, 32'h203, q);
    for (int i = 0; i < 3; i++) offer(32'h7 + i, 32'h40 * i, 2);
    drain(3);
    bus(0, IRQ_ST_OFS, '0, q);
    chk("spacing flag", {31'h0, q[IRQ_SPACE]}, 32'h0);
    // a clear while the set is in flight must drop its result
    src_u.send(32'h1, 32'h2, 1);
    src_u.idle();
    clr <= 1'b1;
    @(posedge mclk);
    clr <= 1'b0;
    drain(3);
    $display("test stream done");
    offer(32'h5, 32'h6, 1);
    src_u.send(32'h9, 32'h9, 1);
    chk("ready", {31'h0, rdy}, 32'h0);
    src_u.idle();
    drain(3);
    bus(0, IRQ_ST_OFS, '0, q);
    chk("spacing flag", {31'h0, q[IRQ_SPACE]}, 32'h1);
    bus(1, IRQ_MASK_OFS, 32'h0, q);
    repeat (2) @(posedge mclk);
    chk("irq masked", {31'h0, irq}, 32'h0);
    bus(1, IRQ_MASK_OFS, 32'h2, q);
    repeat (2) @(posedge mclk);
    chk("irq raised", {31'h0, irq}, 32'h1);
    bus(1, IRQ_ST_OFS, 32'h2, q);
    repeat (2) @(posedge mclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test refusal and interrupt done");
    close_out();
  end
endmodule
